// ### cscp_port.v
`timescale 1ns/10ps
`default_nettype none
`include "cscp_consts.vh"
// Contract
// - three-wire samples data on clock rise
// - three-wire frame: 7 address, 9 data
// - chip select rise commits the frame
// - readback needs enable bit four set
// - bit three picks continuous or addressed
// - continuous: status in last eight bits
// - select field picks status byte
// - three-wire output driven only while select low
// - addressed status read returns the selected status byte
// - start: data falls while clock high
// - shift address and direction, msb first
// - acknowledge matching device address
// - mismatch: idle until next start
// - two bytes: address+d8, then d7..d0
// - acknowledge each control byte
// - stop ends transfer, back to idle
// - stray start or stop aborts transfer
// - address chosen by chip select level
// - two-wire readback on output pin too
// - write to reset register restores defaults
// - reset leaves device powered down
// - interface pin: low two-wire, high three
// - active only with hardware pin low
module cscp_port (
  input  wire       clk,                  // 10 mhz core clock
  input  wire       rst,                  // sync reset, active high
  input  wire       serial_clock,         // host serial clock
  input  wire       serial_data_input,    // data line level
  input  wire       chip_select_n,        // chip select / address strap
  input  wire       interface_select_pin, // 0 two-wire, 1 three-wire
  input  wire       hardware_control_pin, // 1 disables this port
  input  wire [8:0] status_error,         // error status byte
  input  wire [7:0] status_chan1,         // channel status 1
  input  wire [7:0] status_chan2,         // channel status 2
  input  wire [7:0] status_chan3,         // channel status 3
  input  wire [7:0] status_chan4,         // channel status 4
  input  wire [7:0] status_chan5,         // channel status 5
  input  wire [7:0] status_spdif,         // s/pdif status
  output wire       sdi_out,              // data line pull low
  output wire       sdi_oe,               // data line drive enable
  output reg        serial_data_output,   // readback data
  output wire       readback_oe,          // readback drive enable
  output reg        reg_write,            // one-cycle write strobe
  output reg  [6:0] reg_addr,             // committed address
  output reg  [8:0] reg_data,             // committed data
  output reg  [8:0] readback_control_reg, // readback control
  output reg  [8:0] power_control_reg,    // power control bits
  output reg        soft_reset            // register reset pulse
);
  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  reg [1:0] sck_s;   // serial clock sync
  reg [1:0] sda_s;   // data sync
  reg [1:0] csn_s;   // chip select sync
  reg [1:0] ifs_s;   // interface pin sync
  reg [1:0] hw_s;    // hardware pin sync
  reg       sck_d;   // delayed clock for edges
  reg       sda_d;   // delayed data for edges
  reg       csn_d;   // delayed chip select

  // two flops before any logic reads a pin
  always @(posedge clk) begin
    if (rst) begin
      sck_s <= 2'h0;
      sda_s <= 2'h3;
      csn_s <= 2'h3;
      ifs_s <= 2'h0;
      hw_s  <= 2'h3;
      sck_d <= 1'b0;
      sda_d <= 1'b1;
      csn_d <= 1'b1;
    end else begin
      sck_s <= {sck_s[0], serial_clock};
      sda_s <= {sda_s[0], serial_data_input};
      csn_s <= {csn_s[0], chip_select_n};
      ifs_s <= {ifs_s[0], interface_select_pin};
      hw_s  <= {hw_s[0], hardware_control_pin};
      sck_d <= sck_s[1];
      sda_d <= sda_s[1];
      csn_d <= csn_s[1];
    end
  end

  wire sck      = sck_s[1];
  wire sda      = sda_s[1];
  wire csn      = csn_s[1];
  wire sck_rise = sck & ~sck_d;
  wire sck_fall = ~sck & sck_d;
  wire sw_on    = ~hw_s[1];
  wire three    = ifs_s[1] & sw_on;
  wire two      = ~ifs_s[1] & sw_on;
  wire start_c  = two & sck & sck_d & sda_d & ~sda;
  wire stop_c   = two & sck & sck_d & ~sda_d & sda;

  // ----------------------------------------
  // status byte selection
  // ----------------------------------------
  // status byte mux
  function [7:0] pick;
    input [2:0] s;
    begin
      case (s)
        `CSCP_SEL_ERROR: pick = status_error[7:0];
        3'h1:            pick = status_chan1;
        3'h2:            pick = status_chan2;
        3'h3:            pick = status_chan3;
        3'h4:            pick = status_chan4;
        3'h5:            pick = status_chan5;
        `CSCP_SEL_SPDIF: pick = status_spdif;
        default:         pick = 8'h00;
      endcase
    end
  endfunction

  wire       rb_en   = readback_control_reg[`CSCP_RB_EN_BIT];
  wire       rb_cont = readback_control_reg[`CSCP_RB_CONT_BIT];
  wire [2:0] rb_sel  = readback_control_reg[`CSCP_RB_SEL_MSB:`CSCP_RB_SEL_LSB];

  // ----------------------------------------
  // shift state shared by both protocols
  // ----------------------------------------
  localparam ST_IDLE = 3'h0;  // waiting for start
  localparam ST_DEV  = 3'h1;  // device address byte
  localparam ST_ACK  = 3'h2;  // acknowledge slot
  localparam ST_DATA = 3'h3;  // control byte
  localparam ST_WAIT = 3'h4;  // ignore until start/stop

  reg [2:0]  state_reg;   // two-wire state
  reg [15:0] shift_reg;   // incoming bits
  reg [4:0]  count_reg;   // bits seen in frame
  reg        ack_reg;     // pulling data low
  reg [1:0]  ackn_reg;    // ack slots given
  reg [7:0]  rb_shift;    // outgoing status byte
  reg        rb_act;      // readback active
  reg        commit;      // frame ready to commit
  reg [15:0] frame;       // frame to commit

  wire [6:0] my_addr = csn ? `CSCP_DEV_ADDR_HI : `CSCP_DEV_ADDR_LO;
  wire [15:0] shifted = {shift_reg[14:0], sda};

  // readback decision: with enable set, continuous on any write, else status address
  // addressed status read
  function rb_hit;
    input [6:0] a;
    begin
      rb_hit = rb_en & (rb_cont | (a < `CSCP_ADDR_READBACK && a >= `CSCP_ADDR_STAT_LO));
    end
  endfunction

  // protocol engine
  always @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      shift_reg <= 16'h0000;
      count_reg <= 5'h00;
      ack_reg   <= 1'b0;
      ackn_reg  <= 2'h0;
      rb_shift  <= 8'h00;
      rb_act    <= 1'b0;
      commit    <= 1'b0;
      frame     <= 16'h0000;
    end else begin
      commit <= 1'b0;
      if (three) begin
        state_reg <= ST_IDLE;
        ack_reg   <= 1'b0;
        if (csn) begin
          if (~csn_d && count_reg == `CSCP_FRAME_BITS) begin
            commit <= 1'b1;
            frame  <= shift_reg;
          end
          count_reg <= 5'h00;
          rb_act    <= 1'b0;
        end else if (sck_rise) begin
          shift_reg <= shifted;
          if (count_reg != 5'h1f)
            count_reg <= count_reg + 5'h01;
          // after 8 bits, status replaces
          // address sits above the data bit after eight rises
          if (count_reg == 5'h07 && rb_hit(shifted[7:1])) begin
            rb_act   <= 1'b1;
            rb_shift <= pick(rb_sel);
          end else if (rb_act) begin
            rb_shift <= {rb_shift[6:0], 1'b0};
          end
        end
      end else if (two) begin
        if (start_c) begin
          state_reg <= ST_DEV;
          count_reg <= 5'h00;
          ack_reg   <= 1'b0;
          rb_act    <= 1'b0;
        end else if (stop_c) begin
          if (state_reg == ST_WAIT && ackn_reg == 2'h3) begin
            commit <= 1'b1;
            frame  <= shift_reg;
          end
          state_reg <= ST_IDLE;
          ack_reg   <= 1'b0;
          rb_act    <= 1'b0;
        end else begin
          case (state_reg)
            ST_IDLE: ack_reg <= 1'b0;
            ST_DEV, ST_DATA: begin
              if (sck_rise) begin
                shift_reg <= shifted;
                count_reg <= count_reg + 5'h01;
                if (rb_act)
                  rb_shift <= {rb_shift[6:0], 1'b0};
              end else if (sck_fall && count_reg[2:0] == 3'h0 && count_reg != 5'h00) begin
                if (state_reg == ST_DEV) begin
                  if (shift_reg[7:1] == my_addr) begin
                    ack_reg   <= 1'b1;
                    ackn_reg  <= 2'h1;
                    count_reg <= 5'h00;
                    state_reg <= ST_ACK;
                  end else
                    state_reg <= ST_IDLE;
                end else begin
                  ack_reg   <= 1'b1;
                  ackn_reg  <= ackn_reg + 2'h1;
                  state_reg <= ST_ACK;
                  if (count_reg == 5'h08 && rb_hit(shift_reg[7:1])) begin
                    rb_act   <= 1'b1;
                    rb_shift <= pick(rb_sel);
                  end
                end
              end
            end
            ST_ACK: begin
              if (sck_fall) begin
                ack_reg   <= 1'b0;
                state_reg <= (ackn_reg == 2'h3) ? ST_WAIT : ST_DATA;
              end
            end
            ST_WAIT: ack_reg <= 1'b0;
            default: state_reg <= ST_IDLE;
          endcase
        end
      end else begin
        state_reg <= ST_IDLE;
        ack_reg   <= 1'b0;
        rb_act    <= 1'b0;
      end
    end
  end

  assign sdi_out = 1'b0;
  assign sdi_oe  = ack_reg;

  assign readback_oe = three ? ~csn : (two & rb_act);

  // output bit, changes after a rising clock
  always @(posedge clk) begin
    if (rst)
      serial_data_output <= 1'b0;
    else
      serial_data_output <= rb_act ? rb_shift[7] : 1'b0;
  end

  // ----------------------------------------
  // register file
  // ----------------------------------------
  // commit, readback control and software reset
  always @(posedge clk) begin
    if (rst) begin
      reg_write            <= 1'b0;
      reg_addr             <= 7'h00;
      reg_data             <= 9'h000;
      readback_control_reg <= `CSCP_RB_RESET;
      power_control_reg    <= `CSCP_PWR_RESET;
      soft_reset           <= 1'b0;
    end else begin
      reg_write  <= 1'b0;
      soft_reset <= 1'b0;
      if (commit) begin
        reg_write <= 1'b1;
        reg_addr  <= frame[15:9];
        reg_data  <= frame[8:0];
        if (frame[15:9] == `CSCP_ADDR_SWRESET) begin
          readback_control_reg <= `CSCP_RB_RESET;
          power_control_reg    <= `CSCP_PWR_RESET;
          soft_reset           <= 1'b1;
        end else if (frame[15:9] == `CSCP_ADDR_READBACK)
          readback_control_reg <= frame[8:0];
      end
    end
  end
endmodule // cscp_port
`default_nettype wire

// ### cscp_consts.vh
`ifndef CSCP_CONSTS_VH
`define CSCP_CONSTS_VH
// register addresses
`define CSCP_ADDR_READBACK 7'h34
`define CSCP_ADDR_SWRESET  7'h35
`define CSCP_ADDR_STAT_LO  7'h2c
// readback control fields
`define CSCP_RB_SEL_MSB    2
`define CSCP_RB_SEL_LSB    0
`define CSCP_RB_CONT_BIT   3
`define CSCP_RB_EN_BIT     4
`define CSCP_RB_RESET      9'h000
// status register codes
`define CSCP_SEL_ERROR     3'h0
`define CSCP_SEL_SPDIF     3'h6
// two-wire device addresses
`define CSCP_DEV_ADDR_LO   7'h1a
`define CSCP_DEV_ADDR_HI   7'h1b
// power control default: powered down
`define CSCP_PWR_RESET     9'h1ff
// frame sizes
`define CSCP_FRAME_BITS    5'h10
`define CSCP_RB_BITS       4'h8
`endif

// ### cscp_port_properties.sv
`timescale 1ns/10ps
`default_nettype none
// -------------
// port checks
// -------------
module cscp_port_properties (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       chip_select_n,
  input wire logic       interface_select_pin,
  input wire logic       hardware_control_pin,
  input wire logic       sdi_oe,
  input wire logic       readback_oe,
  input wire logic       reg_write,
  input wire logic [6:0] reg_addr,
  input wire logic [8:0] reg_data,
  input wire logic [8:0] readback_control_reg,
  input wire logic [8:0] power_control_reg,
  input wire logic       soft_reset
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  logic [4:0] ack_len_reg; // cycles the ack has been driven
  // counter, since a stuck pull-down would hang the bus
  always @(posedge clk) ack_len_reg <= (rst || !sdi_oe) ? 5'h00 : ack_len_reg + 5'h01;
  a_readback_float: assert property ((interface_select_pin && chip_select_n) [*5] |-> !readback_oe)
    else $error("readback pin driven while deselected");
  a_hold_addr_data: assert property (!reg_write && !soft_reset |-> $stable(reg_addr) && $stable(reg_data))
    else $error("committed word moved without a write");
  a_swreset_pulse: assert property (reg_write && reg_addr == 7'h35 |-> ##[0:2] soft_reset)
    else $error("reset register write gave no reset");
  a_reset_defaults: assert property (soft_reset |->
    ##[0:1] (readback_control_reg == 9'h000 && power_control_reg == 9'h1ff))
    else $error("defaults not restored");
  a_rb_update: assert property (reg_write && reg_addr == 7'h34 |-> ##[0:1] readback_control_reg == reg_data)
    else $error("readback control not written");
  a_hw_mode_quiet: assert property (hardware_control_pin [*8] |-> !reg_write && !sdi_oe)
    else $error("port active in hardware mode");
  a_ack_two_wire: assert property (interface_select_pin [*5] |-> !sdi_oe)
    else $error("ack in three-wire mode");
  a_ack_len_bound: assert property (ack_len_reg <= 5'h0c)
    else $error("ack held too long");
  c_write: cover property (reg_write && reg_addr == 7'h34);
  c_ack: cover property (sdi_oe);
  c_soft_reset: cover property (soft_reset);
endmodule // cscp_port_properties
bind cscp_port cscp_port_properties u_props (
  .clk, .rst, .chip_select_n, .interface_select_pin, .hardware_control_pin, .sdi_oe, .readback_oe,
  .reg_write, .reg_addr, .reg_data, .readback_control_reg, .power_control_reg, .soft_reset);
`default_nettype wire

// ### cscp_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------
// host controller
// ------------------
module cscp_host_model (
  input  wire logic clk,    // paces the host
  input  wire logic sdi_oe, // device pull-down
  input  wire logic rb_pin, // readback pin
  output var  logic sclk,   // still outside frames
  output var  logic cs_n,   // also address strap
  output wire logic sda     // resolved data line
);
  logic drv = 1'b1; // host level, high = released
  initial sclk = 1'b0;
  initial cs_n = 1'b1;
  assign sda = drv & ~sdi_oe;
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // msb first, select low through the read
  task automatic spi(input logic [15:0] f, input int n, output logic [7:0] rx);
    cs_n <= 1'b0;
    sclk <= 1'b0;
    for (int i = 0; i < n; i++) begin
      drv <= f[15-i];
      wt(4);
      if (i >= 8) rx = {rx[6:0], rb_pin};
      sclk <= 1'b1;
      wt(4);
      sclk <= 1'b0;
    end
    wt(4);
    cs_n <= 1'b1;
    drv <= ~drv; // stale data must not linger
    wt(8);
  endtask
  task automatic start2();
    drv <= 1'b1;
    wt(2);
    sclk <= 1'b1;
    wt(4);
    drv <= 1'b0;
    wt(4);
    sclk <= 1'b0;
  endtask
  // msb first, line released for the ack
  task automatic byte2(input logic [7:0] b, output logic ack);
    for (int i = 0; i < 9; i++) begin
      wt(2);
      drv <= (i < 8) ? b[7-i] : 1'b1;
      wt(2);
      sclk <= 1'b1;
      wt(3);
      ack = ~sda;
      wt(1);
      sclk <= 1'b0;
    end
  endtask
  task automatic stop2();
    wt(2);
    drv <= 1'b0;
    wt(2);
    sclk <= 1'b1;
    wt(4);
    drv <= 1'b1;
    wt(8);
  endtask
  task automatic wr2(input logic [6:0] dev, input logic [15:0] f, output logic [2:0] a);
    start2();
    byte2({dev, 1'b0}, a[2]);
    byte2(f[15:8], a[1]);
    byte2(f[7:0], a[0]);
    stop2();
  endtask
endmodule // cscp_host_model
`default_nettype wire

// ### tb_codec_serial_control_port.sv
`timescale 1ns/10ps
`default_nettype none
// --------------------
// control port bench
// --------------------
module tb_codec_serial_control_port;
  logic       clk;          // core clock
  logic       rst = 1'b1;   // sync reset
  logic       isp = 1'b1;   // 1 three-wire
  logic       hwp = 1'b0;   // hardware mode pin
  logic [7:0] rx;           // readback byte
  logic [2:0] ack;          // two-wire acks
  int         err_count = 0;
  int         checks_done = 0;
  wire        sclk, sda, cs_n, sdi_oe, sdi_out, rb_data, rb_oe;
  wire  [6:0] ra;
  wire  [8:0] rd, rbc, pwr;
  logic [7:0] st [0:7] = '{8'h81, 8'h12, 8'h23, 8'h34, 8'h45, 8'h56, 8'hc7, 8'h00};
  // frame, then readback control expected
  logic [24:0] rows [0:3] = '{{7'h34, 9'h1ff, 9'h1ff}, {7'h34, 9'h0a5, 9'h0a5},
    {7'h02, 9'h155, 9'h0a5}, {7'h34, 9'h000, 9'h000}};
  // open-drain ack line; an undriven readback pin shows the inverse of its last bit
  cscp_host_model u_host (.clk(clk), .sdi_oe(sdi_oe && !sdi_out), .rb_pin(rb_oe ? rb_data : ~rb_data),
    .sclk(sclk), .cs_n(cs_n), .sda(sda));
  cscp_port u_dut (
    .clk(clk), .rst(rst), .serial_clock(sclk), .serial_data_input(sda), .chip_select_n(cs_n),
    .interface_select_pin(isp), .hardware_control_pin(hwp), .status_error({1'b0, st[0]}),
    .status_chan1(st[1]), .status_chan2(st[2]), .status_chan3(st[3]), .status_chan4(st[4]),
    .status_chan5(st[5]), .status_spdif(st[6]), .sdi_out(sdi_out), .sdi_oe(sdi_oe),
    .serial_data_output(rb_data), .readback_oe(rb_oe), .reg_write(), .reg_addr(ra), .reg_data(rd),
    .readback_control_reg(rbc), .power_control_reg(pwr), .soft_reset());
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog, run needs about 5000 cycles
  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    test_done();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk(rbc, 9'h000);
    chk(pwr, 9'h1ff);
    foreach (rows[i]) begin
      u_host.spi(rows[i][24:9], 16, rx);
      chk({2'h0, ra}, {2'h0, rows[i][24:18]});
      chk(rd, rows[i][17:9]);
      chk(rbc, rows[i][8:0]);
    end
    // short frame is dropped
    u_host.spi({7'h34, 9'h01f}, 15, rx);
    chk(rbc, 9'h000);
    // every status select, continuous readback
    for (int s = 0; s < 8; s++) begin
      u_host.spi({7'h34, 6'h03, s[2:0]}, 16, rx);
      u_host.spi(16'h0000, 16, rx);
      chk({1'b0, rx}, {1'b0, st[s]});
    end
    // addressed readback: only a status address answers
    u_host.spi({7'h34, 9'h010}, 16, rx);
    u_host.spi({7'h00, 9'h000}, 16, rx);
    chk({1'b0, rx}, 9'h000);
    u_host.spi({7'h2c, 9'h000}, 16, rx);
    chk({1'b0, rx}, {1'b0, st[0]});
    // enable bit clear: continuous set but silent
    u_host.spi({7'h34, 9'h008}, 16, rx);
    u_host.spi({7'h2c, 9'h000}, 16, rx);
    chk({1'b0, rx}, 9'h000);
    isp <= 1'b0;
    repeat (8) @(posedge clk);
    u_host.wr2(7'h1b, {7'h34, 9'h0c7}, ack);
    chk({6'h00, ack}, 9'h007);
    chk(rbc, 9'h0c7);
    u_host.wr2(7'h1a, {7'h34, 9'h011}, ack);
    chk({6'h00, ack}, 9'h000);
    // stop right after the first control byte
    u_host.start2();
    u_host.byte2(8'h36, ack[0]);
    u_host.byte2(8'h68, ack[0]);
    u_host.stop2();
    chk(rbc, 9'h0c7);
    u_host.wr2(7'h1b, {7'h35, 9'h0a5}, ack);
    chk(rbc, 9'h000);
    chk(pwr, 9'h1ff);
    // hardware mode leaves the port deaf
    isp <= 1'b1;
    hwp <= 1'b1;
    repeat (8) @(posedge clk);
    u_host.spi({7'h34, 9'h0ff}, 16, rx);
    chk(rbc, 9'h000);
    // port wakes again once the hardware pin drops
    hwp <= 1'b0;
    repeat (4) @(posedge clk);
    u_host.spi({7'h34, 9'h0ff}, 16, rx);
    chk(rbc, 9'h0ff);
    // reset in mid-run restores defaults
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk(rbc, 9'h000);
    chk({2'h0, ra}, 9'h000);
    chk(pwr, 9'h1ff);
    test_done();
  end
endmodule // tb_codec_serial_control_port
`default_nettype wire
